// file: verilog/tcc_pkg.sv
// Purpose: Shared constants and types for the timer capture/compare block
// Assumes: 8-bit internal bus between controller and device
// Notes: Device addresses are four-bit word indices
package tcc_pkg;
    localparam logic [3:0] DEV_CAP_LOW = 4'h0;
    localparam logic [3:0] DEV_CAP_HIGH = 4'h1;
    localparam logic [3:0] DEV_CMPA_LOW = 4'h2;
    localparam logic [3:0] DEV_CMPA_HIGH = 4'h3;
    localparam logic [3:0] DEV_CMPB_LOW = 4'h4;
    localparam logic [3:0] DEV_CMPB_HIGH = 4'h5;
    localparam logic [3:0] DEV_CTRL = 4'h6;
    localparam logic [3:0] DEV_MODE = 4'h7;
    localparam logic [3:0] DEV_IRQ_EN = 4'h8;
    localparam logic [3:0] DEV_FLAGS = 4'h9;
    localparam logic [3:0] DEV_FORCE = 4'hA;
    localparam int CTRL_FILTER_BIT = 0;
    localparam int CTRL_EDGE_BIT = 1;
    localparam int CTRL_SRC_BIT = 2;
    localparam int MODE_WGM_LSB = 0;
    localparam int MODE_COMA_LSB = 4;
    localparam int MODE_COMB_LSB = 6;
    localparam int FLAG_CAP_BIT = 0;
    localparam int FLAG_CMPA_BIT = 1;
    localparam int FLAG_CMPB_BIT = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam int FILTER_DEPTH = 4;
    localparam logic [11:0] HOST_CMD = 12'h000;
    localparam logic [11:0] HOST_STATUS = 12'h004;
    localparam logic [11:0] HOST_ACK = 12'h008;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_WR_BIT = 16;
    localparam int CMD_RD_BIT = 17;
    localparam int STAT_DATA_LSB = 8;
    localparam int STAT_IRQ_LSB = 16;

    typedef enum logic [1:0] {
        TCC_IDLE,
        TCC_ISSUE,
        TCC_CAPT
    } tcc_host_state_t;
endpackage

// file: verilog/tcc_link_if.sv
// Purpose: Internal 8-bit bus between controller and capture/compare device
// Assumes: Both ends clocked by the same pclk
// Notes: Strobes are one-cycle pulses
`timescale 1ns/1ps
interface tcc_link_if;
    logic [3:0] bus_addr;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic [2:0] irq_req;
    logic [2:0] irq_ack;

    modport device (
        input bus_addr, bus_wr, bus_rd, bus_wdata, irq_ack,
        output bus_rdata, irq_req
    );
    modport host (
        output bus_addr, bus_wr, bus_rd, bus_wdata, irq_ack,
        input bus_rdata, irq_req
    );
endinterface

// file: verilog/tcc_noise_filter.sv
// Purpose: Four-sample majority-free noise filter for the capture input
// Assumes: level_in already sampled on pclk
// Notes: Disabled path has one cycle, enabled path four more
`timescale 1ns/1ps
module tcc_noise_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic level_in,
    output logic level_out
);
    typedef struct packed {
        logic [tcc_pkg::FILTER_DEPTH-1:0] hist;
        logic out;
    } tcc_filt_t;

    tcc_filt_t s_reg;
    tcc_filt_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.hist = {s_reg.hist[tcc_pkg::FILTER_DEPTH-2:0], level_in};
        if (!enable)
        begin
            s_next.out = level_in;
        end
        else if (&s_reg.hist)
        begin
            s_next.out = 1'b1;
        end
        else if (~|s_reg.hist)
        begin
            s_next.out = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign level_out = s_reg.out;
endmodule

// file: verilog/tcc_device.sv
// Purpose: Input capture and two output compare channels of a 16-bit timer
// Assumes: Counter, prescaler and pin logic live outside; inputs synchronous
// Notes: Shared high-byte temporary register serves capture and compare writes
// Function
// - Matching edge captures counter
// - Capture flag set with copy
// - Capture flag irq; ack or w1c clears
// - Low read latches high byte
// - Capture writable only as top
// - Select bit picks comparator source
// - Filter needs four equal samples
// - Capture idle when capture is top
// - Port output can trigger capture
// - New capture overwrites unread value
// - Software flips edge, clears flag
// - Match sets flag next tick
// - Compare flag irq; ack or w1c clears
// - Channel A can define top
// - PWM modes double buffer compares
// - CPU reaches buffer or register
// - High byte via temp, low commits
// - Force acts like match in non-PWM modes, no flag
// - Counter write blocks next-tick matches
// - Software avoids counter write at top
// - Output state kept across modes
// - Output mode bits act at once
// - Reset clears output states
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module tcc_device (
    input wire logic pclk,
    input wire logic presetn,
    tcc_link_if.device link,
    input wire logic [15:0] counter_value,
    input wire logic timer_tick,
    input wire logic counter_written,
    input wire logic at_top,
    input wire logic at_bottom,
    input wire logic capture_pin,
    input wire logic capture_port_out,
    input wire logic capture_port_is_output,
    input wire logic comparator_output,
    output logic [1:0] compare_output_state,
    output logic [15:0] top_value
);
    typedef struct packed {
        logic [7:0] temp;
        logic [15:0] cap;
        logic [1:0][15:0] ocr;
        logic [1:0][15:0] buff;
        logic [1:0] ocs;
        logic [2:0] flags;
        logic [2:0] ien;
        logic [2:0] ctrl;
        logic [7:0] mode;
        logic sample;
        logic prev;
        logic block;
        logic [7:0] rdata;
        logic [2:0] irq;
        logic [15:0] top;
    } tcc_dev_t;

    tcc_dev_t s_reg;
    tcc_dev_t s_next;
    logic filtered;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_pwm(input logic [3:0] m);
        return !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
    endfunction

    function automatic logic cap_is_top(input logic [3:0] m);
        return (m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE);
    endfunction

    function automatic logic upd_at_bottom(input logic [3:0] m);
        return (m == 4'h8 || m == 4'h9);
    endfunction

    function automatic logic [15:0] pick_top(input logic [3:0] m,
                                             input logic [15:0] cap,
                                             input logic [15:0] cmpa);
        case (m)
            4'h1, 4'h5: pick_top = tcc_pkg::TOP_8BIT;
            4'h2, 4'h6: pick_top = tcc_pkg::TOP_9BIT;
            4'h3, 4'h7: pick_top = tcc_pkg::TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: pick_top = cmpa;
            4'h8, 4'hA, 4'hC, 4'hE: pick_top = cap;
            default: pick_top = tcc_pkg::TOP_MAX;
        endcase
    endfunction

    // Non-PWM compare action, also used by force
    function automatic logic com_match(input logic [1:0] com, input logic cur);
        case (com)
            2'h1: com_match = ~cur;
            2'h2: com_match = 1'b0;
            2'h3: com_match = 1'b1;
            default: com_match = cur;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    tcc_noise_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .enable(s_reg.ctrl[tcc_pkg::CTRL_FILTER_BIT]),
        .level_in(s_reg.sample),
        .level_out(filtered)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [3:0] wgm;
        logic [1:0] com;
        logic pwm;
        logic xfer;
        logic src;
        logic [2:0] set_f;
        logic [2:0] clr_f;
        wgm = s_reg.mode[tcc_pkg::MODE_WGM_LSB +: 4];
        com = 2'h0;
        pwm = is_pwm(wgm);
        xfer = 1'b0;
        set_f = 3'h0;
        clr_f = link.irq_ack;
        s_next = s_reg;

        // Port drives the pin when it is an output
        src = capture_port_is_output ? capture_port_out : capture_pin;
        if (s_reg.ctrl[tcc_pkg::CTRL_SRC_BIT])
        begin
            src = comparator_output;
        end
        s_next.sample = src;

        // Capture path
        s_next.prev = filtered;
        if (!cap_is_top(wgm) && filtered != s_reg.prev &&
            filtered == s_reg.ctrl[tcc_pkg::CTRL_EDGE_BIT])
        begin
            s_next.cap = counter_value;
            set_f[tcc_pkg::FLAG_CAP_BIT] = 1'b1;
        end

        // Matches in the tick right after a counter write are dropped
        if (counter_written)
        begin
            s_next.block = 1'b1;
        end
        else if (timer_tick)
        begin
            s_next.block = 1'b0;
        end

        // Compare channels
        for (int ch = 0; ch < 2; ch++)
        begin
            com = s_reg.mode[tcc_pkg::MODE_COMA_LSB + 2 * ch +: 2];
            xfer = pwm && timer_tick &&
                   (upd_at_bottom(wgm) ? at_bottom : at_top);
            if (xfer)
            begin
                s_next.ocr[ch] = s_reg.buff[ch];
            end
            if (timer_tick && pwm && at_top)
            begin
                if (com == 2'h2)
                begin
                    s_next.ocs[ch] = 1'b0;
                end
                else if (com == 2'h3)
                begin
                    s_next.ocs[ch] = 1'b1;
                end
            end
            if (timer_tick && !s_reg.block && counter_value == s_reg.ocr[ch])
            begin
                set_f[tcc_pkg::FLAG_CMPA_BIT + ch] = 1'b1;
                if (!pwm)
                begin
                    s_next.ocs[ch] = com_match(com, s_reg.ocs[ch]);
                end
                else if (com == 2'h2)
                begin
                    s_next.ocs[ch] = 1'b1;
                end
                else if (com == 2'h3)
                begin
                    s_next.ocs[ch] = 1'b0;
                end
            end
            if (link.bus_wr && link.bus_addr == tcc_pkg::DEV_FORCE &&
                link.bus_wdata[ch] && !pwm)
            begin
                s_next.ocs[ch] = com_match(com, s_reg.ocs[ch]);
            end
        end

        // Bus writes
        if (link.bus_wr)
        begin
            case (link.bus_addr)
                tcc_pkg::DEV_CAP_HIGH, tcc_pkg::DEV_CMPA_HIGH,
                tcc_pkg::DEV_CMPB_HIGH:
                begin
                    s_next.temp = link.bus_wdata;
                end
                tcc_pkg::DEV_CAP_LOW:
                begin
                    if (cap_is_top(wgm))
                    begin
                        s_next.cap = {s_reg.temp, link.bus_wdata};
                    end
                end
                tcc_pkg::DEV_CMPA_LOW, tcc_pkg::DEV_CMPB_LOW:
                begin
                    // Address bit 2 tells channel B from channel A
                    s_next.buff[link.bus_addr[2]] = {s_reg.temp, link.bus_wdata};
                    if (!pwm)
                    begin
                        s_next.ocr[link.bus_addr[2]] = {s_reg.temp, link.bus_wdata};
                    end
                end
                tcc_pkg::DEV_CTRL: s_next.ctrl = link.bus_wdata[2:0];
                tcc_pkg::DEV_MODE: s_next.mode = link.bus_wdata;
                tcc_pkg::DEV_IRQ_EN: s_next.ien = link.bus_wdata[2:0];
                tcc_pkg::DEV_FLAGS: clr_f = clr_f | link.bus_wdata[2:0];
                default: s_next.temp = s_reg.temp;
            endcase
        end

        // Hardware set beats a simultaneous clear
        s_next.flags = (s_reg.flags & ~clr_f) | set_f;

        // Bus reads, answered one cycle after the strobe
        s_next.rdata = 8'h00;
        if (link.bus_rd)
        begin
            case (link.bus_addr)
                tcc_pkg::DEV_CAP_LOW:
                begin
                    s_next.rdata = s_reg.cap[7:0];
                    s_next.temp = s_reg.cap[15:8];
                end
                tcc_pkg::DEV_CAP_HIGH: s_next.rdata = s_reg.temp;
                tcc_pkg::DEV_CMPA_LOW, tcc_pkg::DEV_CMPB_LOW:
                    s_next.rdata = pwm ? s_reg.buff[link.bus_addr[2]][7:0] :
                                         s_reg.ocr[link.bus_addr[2]][7:0];
                tcc_pkg::DEV_CMPA_HIGH, tcc_pkg::DEV_CMPB_HIGH:
                    s_next.rdata = pwm ? s_reg.buff[link.bus_addr[2]][15:8] :
                                         s_reg.ocr[link.bus_addr[2]][15:8];
                tcc_pkg::DEV_CTRL: s_next.rdata = {5'h00, s_reg.ctrl};
                tcc_pkg::DEV_MODE: s_next.rdata = s_reg.mode;
                tcc_pkg::DEV_IRQ_EN: s_next.rdata = {5'h00, s_reg.ien};
                tcc_pkg::DEV_FLAGS: s_next.rdata = {5'h00, s_reg.flags};
                default: s_next.rdata = 8'h00;
            endcase
        end

        s_next.irq = s_next.flags & s_next.ien;
        s_next.top = pick_top(s_next.mode[tcc_pkg::MODE_WGM_LSB +: 4],
                              s_next.cap, s_next.ocr[0]);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '0;
            s_reg.top <= tcc_pkg::TOP_MAX;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.bus_rdata = s_reg.rdata;
    assign link.irq_req = s_reg.irq;
    assign compare_output_state = s_reg.ocs;
    assign top_value = s_reg.top;
endmodule

// file: verilog/tcc_host.sv
// Purpose: APB-controlled master of the device's 8-bit internal bus
// Assumes: Software keeps the byte order for 16-bit values
// Notes: One device access at a time; commands while busy are dropped
`timescale 1ns/1ps
module tcc_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    tcc_link_if.host link
);
    typedef struct packed {
        tcc_pkg::tcc_host_state_t st;
        logic [17:0] cmd;
        logic [7:0] rdata;
        logic [3:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic [2:0] ack;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tcc_host_t;

    tcc_host_t s_reg;
    tcc_host_t s_next;

    always_comb
    begin
        logic mapped;
        logic acc;
        mapped = (paddr == tcc_pkg::HOST_CMD) || (paddr == tcc_pkg::HOST_STATUS) ||
                 (paddr == tcc_pkg::HOST_ACK);
        acc = psel && penable && s_reg.pready && pwrite && mapped;
        s_next = s_reg;
        s_next.wr = 1'b0;
        s_next.rd = 1'b0;
        s_next.ack = 3'h0;
        s_next.pready = psel && !penable;
        s_next.pslverr = psel && !penable && !mapped;
        s_next.prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                tcc_pkg::HOST_CMD: s_next.prdata = {14'h0000, s_reg.cmd};
                tcc_pkg::HOST_STATUS:
                    s_next.prdata = {13'h0000, link.irq_req, s_reg.rdata, 7'h00,
                                     s_reg.st != tcc_pkg::TCC_IDLE};
                default: s_next.prdata = 32'h0000_0000;
            endcase
        end
        case (s_reg.st)
            tcc_pkg::TCC_IDLE:
            begin
                // Writes take effect only at the access edge with pready high
                if (acc && paddr == tcc_pkg::HOST_CMD &&
                    (pwdata[tcc_pkg::CMD_WR_BIT] || pwdata[tcc_pkg::CMD_RD_BIT]))
                begin
                    s_next.cmd = pwdata[17:0];
                    s_next.addr = pwdata[3:0];
                    s_next.wdata = pwdata[tcc_pkg::CMD_DATA_LSB +: 8];
                    s_next.wr = pwdata[tcc_pkg::CMD_WR_BIT];
                    s_next.rd = !pwdata[tcc_pkg::CMD_WR_BIT];
                    s_next.st = tcc_pkg::TCC_ISSUE;
                end
            end
            tcc_pkg::TCC_ISSUE:
            begin
                s_next.st = s_reg.rd ? tcc_pkg::TCC_CAPT : tcc_pkg::TCC_IDLE;
            end
            tcc_pkg::TCC_CAPT:
            begin
                s_next.rdata = link.bus_rdata;
                s_next.st = tcc_pkg::TCC_IDLE;
            end
            default: s_next.st = tcc_pkg::TCC_IDLE;
        endcase
        if (acc && paddr == tcc_pkg::HOST_ACK)
        begin
            s_next.ack = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '0;
            s_reg.st <= tcc_pkg::TCC_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign link.bus_addr = s_reg.addr;
    assign link.bus_wr = s_reg.wr;
    assign link.bus_rd = s_reg.rd;
    assign link.bus_wdata = s_reg.wdata;
    assign link.irq_ack = s_reg.ack;
endmodule

// file: bench/tcc_link_monitor.sv
// Purpose: Checks on the byte link
// Assumes: One clock, async low reset
// Notes: Shadows the irq enable register
`timescale 1ns/1ps
module tcc_link_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic [2:0] irq_req,
    input wire logic [2:0] irq_ack
);
    logic [2:0] en_reg;
    logic en_wr;
    assign en_wr = bus_wr && bus_addr == tcc_pkg::DEV_IRQ_EN;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_reg <= 3'h0;
        else
            en_reg <= en_wr ? bus_wdata[2:0] : en_reg;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("stray read byte");
    a_wr_single: assert property (bus_wr |=> !bus_wr && !bus_rd)
        else $error("long write strobe");
    a_rd_single: assert property (bus_rd |=> !bus_rd && !bus_wr)
        else $error("long read strobe");
    a_ack_pulse: assert property (irq_ack != 3'h0 |=> irq_ack == 3'h0)
        else $error("long irq ack");
    // Old enable still allowed one cycle, though the request flop loads from the next enable and changes with it
    a_irq_gated: assert property ((irq_req & ~en_reg & ~$past(en_reg)) == 3'h0)
        else $error("irq while disabled");
    a_en_drop: assert property (en_wr && bus_wdata[2:0] == 3'h0 |-> ##2 irq_req == 3'h0)
        else $error("irq kept after disable");
    a_ack_clear: assert property (irq_ack[1] && irq_req[1] |-> ##2 !irq_req[1])
        else $error("irq kept after ack");
    a_w1c_clear: assert property (bus_wr && bus_addr == tcc_pkg::DEV_FLAGS && bus_wdata[0]
        && irq_req[0] |-> ##2 !irq_req[0])
        else $error("irq kept after w1c");
endmodule

// file: bench/tb_timer16_capture_compare.sv
// Purpose: Self-checking bench for host and device
// Assumes: Tasks keep the byte order
// Notes: Flags cleared only while no event is due
`timescale 1ns/1ps
module tb_timer16_capture_compare;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, perr;
    logic [15:0] counter_value = 16'h0;
    logic timer_tick = 1'b0;
    logic counter_written = 1'b0;
    logic at_top = 1'b0;
    logic at_bottom = 1'b0;
    logic capture_pin = 1'b0;
    logic capture_port_out = 1'b0;
    logic capture_port_is_output = 1'b0;
    logic comparator_output = 1'b0;
    logic [1:0] compare_output_state;
    logic [15:0] top_value;
    int mismatches = 0;
    int samples_checked = 0;
    tcc_link_if link();
    always #20 pclk = ~pclk;
    tcc_host i_tcc_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    tcc_device i_tcc_device (.pclk(pclk), .presetn(presetn), .link(link),
        .counter_value(counter_value), .timer_tick(timer_tick),
        .counter_written(counter_written), .at_top(at_top), .at_bottom(at_bottom),
        .capture_pin(capture_pin), .capture_port_out(capture_port_out),
        .capture_port_is_output(capture_port_is_output),
        .comparator_output(comparator_output),
        .compare_output_state(compare_output_state), .top_value(top_value));
    tcc_link_monitor i_tcc_link_monitor (.pclk(pclk), .presetn(presetn),
        .bus_addr(link.bus_addr), .bus_wr(link.bus_wr), .bus_rd(link.bus_rd),
        .bus_wdata(link.bus_wdata), .bus_rdata(link.bus_rdata),
        .irq_req(link.irq_req), .irq_ack(link.irq_ack));
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic co(input string nm, input logic [1:0] e);
        chk(nm, {14'h0, e}, {14'h0, compare_output_state});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Idle cycle after each transfer so no signal is assigned twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
        q = prdata;
        perr = pslverr;
        chk("pready", 16'h1, {15'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic dev(input logic rd, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [31:0] s;
        int n;
        n = 0;
        apb(1'b1, tcc_pkg::HOST_CMD, {14'h0, rd, ~rd, d, 4'h0, a}, s);
        do apb(1'b0, tcc_pkg::HOST_STATUS, 32'h0, s); while (s[0] !== 1'b0 && ++n < 20);
        q = s[15:8];
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        dev(1'b0, a, d, q);
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a + 4'h1, v[15:8]);
        wr(a, v[7:0]);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        dev(1'b1, a, 8'h00, v[7:0]);
        dev(1'b1, a + 4'h1, 8'h00, v[15:8]);
    endtask
    task automatic cc(input string nm, input logic [15:0] e);
        logic [15:0] g;
        rd16(tcc_pkg::DEV_CAP_LOW, g);
        chk(nm, e, g);
    endtask
    task automatic cf(input string nm, input logic [7:0] e);
        logic [7:0] f;
        dev(1'b1, tcc_pkg::DEV_FLAGS, 8'h00, f);
        chk(nm, {8'h00, e}, {8'h00, f});
    endtask
    task automatic tick(input logic [15:0] c);
        counter_value <= c;
        timer_tick <= 1'b1;
        @(posedge pclk);
        timer_tick <= 1'b0;
        cyc(3);
    endtask
    task automatic lvl(input logic [15:0] c, input logic p);
        counter_value <= c;
        capture_pin <= p;
        cyc(12);
    endtask
    task automatic ramp(input logic [7:0] ctl, output logic [15:0] d);
        wr(tcc_pkg::DEV_CTRL, ctl);
        lvl(16'h0100, 1'b0);
        capture_pin <= 1'b1;
        repeat (16)
        begin
            @(posedge pclk);
            counter_value <= counter_value + 16'h0001;
        end
        rd16(tcc_pkg::DEV_CAP_LOW, d);
    endtask
    function automatic logic oc_next(input logic [1:0] com, input logic cur);
        return com == 2'h1 ? ~cur : com == 2'h3;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] v, w, d0;
        logic [7:0] b, lo;
        logic [3:0] a;
        logic [31:0] s;
        logic oc;
        void'($urandom(29));
        cyc(4);
        presetn <= 1'b1;
        cyc(1);
        co("oc_reset", 2'h0);
        chk("top_reset", 16'hFFFF, top_value);
        apb(1'b0, 12'h00C, 32'h0, s);
        chk("unmapped", 16'h1, {15'h0, perr});
        for (int i = 0; i < 6; i++)
        begin
            v = (i < 2) ? {16{i[0]}} : 16'($urandom);
            a = i[0] ? tcc_pkg::DEV_CMPB_LOW : tcc_pkg::DEV_CMPA_LOW;
            wr16(a, v);
            rd16(a, w);
            chk("cmp_rw", v, w);
        end
        wr(tcc_pkg::DEV_CMPB_HIGH, 8'h5A);
        rd16(tcc_pkg::DEV_CMPB_LOW, w);
        chk("cmp_half", v, w);
        wr(tcc_pkg::DEV_IRQ_EN, 8'h07);
        wr16(tcc_pkg::DEV_CMPA_LOW, 16'h1234);
        wr(tcc_pkg::DEV_MODE, 8'h10);
        tick(16'h1233);
        cf("cmp_nomatch", 8'h00);
        tick(16'h1234);
        cf("cmp_match", 8'h02);
        co("oc_toggle", 2'h1);
        apb(1'b0, tcc_pkg::HOST_STATUS, 32'h0, s);
        chk("irq_req", 16'h2, {13'h0, s[18:16]});
        apb(1'b1, tcc_pkg::HOST_ACK, 32'h2, s);
        cf("irq_ack", 8'h00);
        counter_written <= 1'b1;
        cyc(1);
        counter_written <= 1'b0;
        tick(16'h1234);
        cf("cmp_blocked", 8'h00);
        tick(16'h1234);
        cf("cmp_unblocked", 8'h02);
        co("oc_back", 2'h0);
        wr(tcc_pkg::DEV_FLAGS, 8'h02);
        cf("cmp_w1c", 8'h00);
        oc = 1'b0;
        for (int c = 1; c < 4; c++)
        begin
            wr(tcc_pkg::DEV_MODE, 8'(c << 4));
            wr(tcc_pkg::DEV_FORCE, 8'h01);
            oc = oc_next(2'(c), oc);
            co("force_oc", {1'b0, oc});
        end
        cf("force_noflag", 8'h00);
        wr(tcc_pkg::DEV_MODE, 8'h2F);
        wr(tcc_pkg::DEV_FORCE, 8'h01);
        co("oc_kept", 2'h1);
        chk("top_cmpa", 16'h1234, top_value);
        wr16(tcc_pkg::DEV_CMPA_LOW, 16'h0456);
        chk("top_buffered", 16'h1234, top_value);
        at_top <= 1'b1;
        tick(16'h0000);
        at_top <= 1'b0;
        chk("top_loaded", 16'h0456, top_value);
        wr(tcc_pkg::DEV_MODE, 8'h00);
        wr(tcc_pkg::DEV_CTRL, 8'h02);
        v = 16'($urandom);
        w = 16'($urandom);
        lvl(v, 1'b1);
        lvl(~v, 1'b0);
        lvl(w, 1'b1);
        lvl(~w, 1'b0);
        cc("cap_last_rise", w);
        cf("cap_flag", 8'h01);
        lvl(~w, 1'b0);
        dev(1'b1, tcc_pkg::DEV_CAP_LOW, 8'h00, lo);
        lvl(w ^ 16'h8000, 1'b1);
        dev(1'b1, tcc_pkg::DEV_CAP_HIGH, 8'h00, b);
        chk("cap_temp", w, {b, lo});
        wr16(tcc_pkg::DEV_CAP_LOW, 16'hABCD);
        cc("cap_locked", w ^ 16'h8000);
        capture_port_is_output <= 1'b1;
        lvl(16'h0, 1'b0);
        wr(tcc_pkg::DEV_FLAGS, 8'h01);
        capture_port_out <= 1'b1;
        lvl(v, 1'b0);
        cc("cap_port", v);
        cf("cap_port_flag", 8'h01);
        wr(tcc_pkg::DEV_CTRL, 8'h06);
        wr(tcc_pkg::DEV_FLAGS, 8'h01);
        comparator_output <= 1'b1;
        lvl(w, 1'b0);
        cc("cap_comp", w);
        capture_port_is_output <= 1'b0;
        ramp(8'h02, d0);
        ramp(8'h03, v);
        chk("filter_delay", d0 + 16'h0004, v);
        lvl(16'h0, 1'b0);
        wr(tcc_pkg::DEV_FLAGS, 8'h01);
        capture_pin <= 1'b1;
        cyc(3);
        capture_pin <= 1'b0;
        cyc(12);
        cf("filter_glitch", 8'h00);
        wr(tcc_pkg::DEV_MODE, 8'h0C);
        wr16(tcc_pkg::DEV_CAP_LOW, 16'h0ABC);
        chk("top_cap", 16'h0ABC, top_value);
        cc("cap_wr", 16'h0ABC);
        lvl(v, 1'b1);
        cf("cap_idle", 8'h00);
        wr(tcc_pkg::DEV_IRQ_EN, 8'h00);
        complete_run();
    end
    // Ample margin over the run
    initial
    begin
        #800000;
        mismatches++;
        complete_run();
    end
endmodule
